// ---- emo_memory_select.sv ----
// Purpose: External memory selects, overlays, wait states and acknowledge pin style
// Assumes: One access request at a time from the core, taken in idle only
// Notes: Registers sit at their data-memory addresses on the register port
// Summary of operation
// - Host mode, style 0: acknowledge actively driven
// - Host mode, style 1: acknowledge open drain
// - Program memory 24 bits, two external overlays
// - Host mode: only A0, no external fetch
// - Program overlay 1 A13 low, 2 high
// - Data overlay decodes the same way
// - Internal data accesses finish in one cycle
// - External data accesses use data wait field
// - Byte-select disable suppresses byte select
// - Serial enables and program wait field
// - I/O: eleven address lines, upper driven zero
// - Four three-bit I/O wait fields
// - I/O regions by address bits ten:nine
// - Composite select follows bus request release
// - Enable bit makes composite follow select
// - Composite enables reset to one except byte
// - Byte memory 256 pages of 16K
// - Byte address from page and A13:0
// - Byte accesses use byte wait field
// - Mode pin sampled during reset only
`timescale 1ns/1ns
`default_nettype none
module emo_memory_select #(
  parameter int WS_W = 5
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic flag_pin_two,
  input wire logic ack_style,
  input wire logic host_ack_busy,
  input wire logic bus_request,
  input wire logic req_valid,
  input wire logic [1:0] req_space,
  input wire logic req_fetch,
  input wire logic [13:0] req_addr,
  input wire logic [7:0] req_page,
  input wire logic reg_write,
  input wire logic reg_read,
  input wire logic [13:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  output logic [15:0] reg_rdata,
  output logic req_done,
  output logic req_refused,
  output logic bus_grant,
  output logic [13:0] ext_addr,
  output logic [7:0] byte_page,
  output logic program_space_select_n,
  output logic data_space_select_n,
  output logic io_space_select_n,
  output logic byte_space_select_n,
  output logic composite_select_n,
  output logic host_acknowledge,
  output logic host_acknowledge_oe,
  output logic host_mode,
  output logic serial_port_zero_en,
  output logic serial_port_one_en,
  output logic serial_port_one_cfg
);
  typedef enum logic [0:0] {ST_IDLE, ST_EXT} emo_state_t;

  if (WS_W < 4)
  begin : g_check
    $error("WS_W too narrow for 15 wait states");
  end

  emo_state_t state;
  logic [15:0] system_control;
  logic [15:0] wait_control;
  logic [15:0] composite_control;
  logic [15:0] overlay;
  logic ack_style_lat;
  logic [1:0] space_lat;
  logic count_zero;

  // Register fields
  wire logic wait_mode = wait_control[emo_pkg::WAIT_MODE_BIT];
  wire logic [2:0] pm_wait = system_control[emo_pkg::SYS_PM_WAIT_LSB +: 3];
  wire logic [2:0] dm_wait = wait_control[emo_pkg::WAIT_DM_LSB +: 3];
  wire logic [3:0] byte_wait = composite_control[emo_pkg::CMS_BYTE_WAIT_LSB +: 4];
  wire logic [3:0] cms_sel = composite_control[emo_pkg::CMS_SEL_LSB +: 4];
  wire logic byte_disable = system_control[emo_pkg::SYS_BYTE_DISABLE];
  wire logic [1:0] pm_ovl = overlay[emo_pkg::OVL_PM_LSB +: 2];
  wire logic [1:0] dm_ovl = overlay[emo_pkg::OVL_DM_LSB +: 2];

  // Request decode
  wire logic in_window = req_addr >= emo_pkg::OVERLAY_BASE;
  wire logic [1:0] req_ovl = (req_space == emo_pkg::SPACE_PM) ? pm_ovl : dm_ovl;
  wire logic ovl_ok = (req_ovl == emo_pkg::OVL_ONE) || (req_ovl == emo_pkg::OVL_TWO);
  wire logic is_mem = (req_space == emo_pkg::SPACE_PM) || (req_space == emo_pkg::SPACE_DM);
  wire logic go_ext = is_mem ? (in_window && ovl_ok) : 1'b1;
  // Only external fetches are refused; internal program memory still runs
  wire logic fetch_refused = host_mode && req_fetch && (req_space == emo_pkg::SPACE_PM) && go_ext;
  wire logic accept = (state == ST_IDLE) && req_valid && !bus_request;
  wire logic accept_ext = accept && go_ext && !fetch_refused;
  wire logic [1:0] io_region = req_addr[emo_pkg::IO_REGION_LSB +: 2];
  wire logic [2:0] io_wait = wait_control[emo_pkg::WAIT_IO_LSB + emo_pkg::WAIT_FIELD_W * io_region +: 3];

  // Wait states per space
  logic [4:0] next_waits;
  always_comb
  begin
    case (req_space)
      emo_pkg::SPACE_PM: next_waits = emo_pkg::wait_count({1'b0, pm_wait}, wait_mode);
      emo_pkg::SPACE_DM: next_waits = emo_pkg::wait_count({1'b0, dm_wait}, wait_mode);
      emo_pkg::SPACE_IO: next_waits = emo_pkg::wait_count({1'b0, io_wait}, wait_mode);
      default: next_waits = emo_pkg::wait_count(byte_wait, wait_mode);
    endcase
  end

  // External address forming
  logic [13:0] next_addr;
  always_comb
  begin
    case (req_space)
      emo_pkg::SPACE_IO: next_addr = {3'h0, req_addr[emo_pkg::IO_ADDR_W-1:0]};
      emo_pkg::SPACE_BYTE: next_addr = req_addr;
      default: next_addr = {req_ovl == emo_pkg::OVL_TWO, req_addr[12:0]};
    endcase
    if (host_mode)
      next_addr = {13'h0, req_addr[0]};
  end

  wire logic end_ext = (state == ST_EXT) && count_zero;
  wire logic [WS_W-1:0] load_value = WS_W'(next_waits);

  emo_wait_counter #(.WS_W(WS_W)) u_wait (
    .clk(clk),
    .reset(reset),
    .load(accept_ext),
    .load_value(load_value),
    .count_zero(count_zero)
  );

  // Access state machine
  always_ff @(posedge clk)
  begin
    if (reset)
      state <= ST_IDLE;
    else
    begin
      case (state)
        ST_IDLE: if (accept_ext) state <= ST_EXT;
        ST_EXT: if (count_zero) state <= ST_IDLE;
        default: state <= ST_IDLE;
      endcase
    end
  end

  // Selected space and addresses held for the access
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      space_lat <= emo_pkg::SPACE_PM;
      ext_addr <= '0;
      byte_page <= '0;
    end
    else if (accept_ext)
    begin
      space_lat <= req_space;
      ext_addr <= next_addr;
      byte_page <= (req_space == emo_pkg::SPACE_BYTE) ? req_page : 8'h00;
    end
  end

  // Individual select levels for the next cycle
  wire logic active_next = accept_ext || ((state == ST_EXT) && !count_zero);
  wire logic [1:0] sp_next = accept_ext ? req_space : space_lat;
  wire logic pm_on = active_next && (sp_next == emo_pkg::SPACE_PM);
  wire logic dm_on = active_next && (sp_next == emo_pkg::SPACE_DM);
  wire logic io_on = active_next && (sp_next == emo_pkg::SPACE_IO);
  wire logic byte_on = active_next && (sp_next == emo_pkg::SPACE_BYTE);
  // Selects are already released while granted, so a stale grant must not open it
  wire logic byte_gate = !byte_disable;
  wire logic cms_on = (pm_on && cms_sel[emo_pkg::CMS_PM]) || (dm_on && cms_sel[emo_pkg::CMS_DM])
                      || (byte_on && cms_sel[emo_pkg::CMS_BYTE]) || (io_on && cms_sel[emo_pkg::CMS_IO]);

  // Active-low selects, high when idle or bus granted
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      program_space_select_n <= 1'b1;
      data_space_select_n <= 1'b1;
      io_space_select_n <= 1'b1;
      byte_space_select_n <= 1'b1;
      composite_select_n <= 1'b1;
    end
    else
    begin
      program_space_select_n <= !pm_on;
      data_space_select_n <= !dm_on;
      io_space_select_n <= !io_on;
      byte_space_select_n <= !(byte_on && byte_gate);
      composite_select_n <= !cms_on;
    end
  end

  // Completion, refusal and bus grant
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      req_done <= 1'b0;
      req_refused <= 1'b0;
      bus_grant <= 1'b0;
    end
    else
    begin
      req_done <= end_ext || (accept && !go_ext && !fetch_refused);
      req_refused <= accept && fetch_refused;
      bus_grant <= bus_request && (state == ST_IDLE) && !accept_ext;
    end
  end

  // Mode captured while reset is held
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      host_mode <= flag_pin_two;
      ack_style_lat <= ack_style;
    end
  end

  // Acknowledge pin drive style
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      host_acknowledge <= 1'b1;
      host_acknowledge_oe <= 1'b0;
    end
    else if (!host_mode)
    begin
      host_acknowledge <= 1'b1;
      host_acknowledge_oe <= 1'b0;
    end
    else if (!ack_style_lat)
    begin
      host_acknowledge <= !host_ack_busy;
      host_acknowledge_oe <= 1'b1;
    end
    else
    begin
      host_acknowledge <= 1'b1;
      host_acknowledge_oe <= !host_ack_busy;
    end
  end

  // Register writes, reserved bits forced to zero
  wire logic [15:0] wmask_data = reg_wdata;
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      system_control <= emo_pkg::SYSCTL_RESET;
      wait_control <= emo_pkg::WAITCTL_RESET;
      composite_control <= emo_pkg::CMSCTL_RESET;
      overlay <= emo_pkg::OVERLAY_RESET;
    end
    else if (reg_write)
    begin
      case (reg_addr)
        emo_pkg::REG_SYSTEM_CONTROL: system_control <= wmask_data & emo_pkg::SYSCTL_MASK;
        emo_pkg::REG_WAIT_CONTROL: wait_control <= wmask_data & emo_pkg::WAITCTL_MASK;
        emo_pkg::REG_COMPOSITE_CONTROL: composite_control <= wmask_data & emo_pkg::CMSCTL_MASK;
        emo_pkg::REG_OVERLAY: overlay <= wmask_data & emo_pkg::OVERLAY_MASK;
        default: overlay <= overlay;
      endcase
    end
  end

  // Register read data and port enables
  logic [15:0] next_rdata;
  always_comb
  begin
    case (reg_addr)
      emo_pkg::REG_SYSTEM_CONTROL: next_rdata = system_control;
      emo_pkg::REG_WAIT_CONTROL: next_rdata = wait_control;
      emo_pkg::REG_COMPOSITE_CONTROL: next_rdata = composite_control;
      emo_pkg::REG_OVERLAY: next_rdata = overlay;
      default: next_rdata = 16'h0000;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      reg_rdata <= 16'h0000;
      serial_port_zero_en <= 1'b0;
      serial_port_one_en <= 1'b0;
      serial_port_one_cfg <= 1'b0;
    end
    else
    begin
      if (reg_read)
        reg_rdata <= next_rdata;
      serial_port_zero_en <= system_control[emo_pkg::SYS_SERIAL_ZERO_EN];
      serial_port_one_en <= system_control[emo_pkg::SYS_SERIAL_ONE_EN];
      serial_port_one_cfg <= system_control[emo_pkg::SYS_SERIAL_ONE_CFG];
    end
  end

  // Helper: select length and expected wait count
  logic [5:0] sel_len;
  logic [4:0] waits_lat;
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      sel_len <= '0;
      waits_lat <= '0;
    end
    else if (accept_ext)
    begin
      sel_len <= 6'h01;
      waits_lat <= next_waits;
    end
    else if (state == ST_EXT)
      sel_len <= sel_len + 6'h01;
  end

  wire logic any_sel = !program_space_select_n || !data_space_select_n || !io_space_select_n
                       || !byte_space_select_n;

  sequence seq_ext_start;
    accept_ext && !fetch_refused;
  endsequence

  sequence seq_select_low;
    any_sel || (byte_disable && space_lat == emo_pkg::SPACE_BYTE);
  endsequence

  chk_ack_driven: assert property (@(posedge clk) disable iff (reset)
    host_mode && !ack_style_lat ##1 1'b1 |-> host_acknowledge_oe)
    else $error("acknowledge not driven in style 0");
  chk_ack_open_drain: assert property (@(posedge clk) disable iff (reset)
    host_mode && ack_style_lat ##1 1'b1 |-> host_acknowledge)
    else $error("acknowledge driven low in open drain style");
  chk_host_addr_a0: assert property (@(posedge clk) disable iff (reset)
    (seq_ext_start and host_mode) |=> ext_addr[13:1] == 13'h0)
    else $error("upper address lines used in host mode");
  chk_pm_overlay_a13: assert property (@(posedge clk) disable iff (reset)
    (seq_ext_start and (!host_mode && req_space == emo_pkg::SPACE_PM))
    |=> !program_space_select_n && ext_addr[13] == (pm_ovl == emo_pkg::OVL_TWO))
    else $error("program overlay address bit 13 wrong");
  chk_dm_reserved: assert property (@(posedge clk) disable iff (reset)
    accept && req_space == emo_pkg::SPACE_DM && dm_ovl == emo_pkg::OVL_RESERVED |=> data_space_select_n)
    else $error("reserved data overlay reached outside");
  chk_internal_one: assert property (@(posedge clk) disable iff (reset)
    accept && !go_ext && !fetch_refused |=> req_done && state == ST_IDLE)
    else $error("internal access not one cycle");
  chk_wait_length: assert property (@(posedge clk) disable iff (reset)
    end_ext |-> sel_len == {1'b0, waits_lat} + 6'h01)
    else $error("external access length differs from wait states");
  chk_io_upper: assert property (@(posedge clk) disable iff (reset)
    !io_space_select_n |-> ext_addr[13:11] == 3'h0)
    else $error("io upper address lines not zero");
  chk_byte_disable: assert property (@(posedge clk) disable iff (reset)
    byte_disable ##1 byte_disable |-> byte_space_select_n)
    else $error("byte select active while disabled");
  chk_cms_follow: assert property (@(posedge clk) disable iff (reset)
    !data_space_select_n && $past(cms_sel[emo_pkg::CMS_DM]) |-> !composite_select_n)
    else $error("composite select missed data select");
  chk_cms_reset: assert property (@(posedge clk)
    $past(reset) && !reset |-> cms_sel == 4'hb && byte_space_select_n)
    else $error("composite enables wrong after reset");
  chk_bus_release: assert property (@(posedge clk) disable iff (reset)
    bus_grant |-> !any_sel && composite_select_n)
    else $error("select active while bus granted");
  chk_select_span: assert property (@(posedge clk) disable iff (reset)
    seq_ext_start ##1 seq_select_low |-> ##[0:17] state == ST_IDLE)
    else $error("external access never ended");
endmodule : emo_memory_select
`default_nettype wire

// ---- emo_pkg.sv ----
// Purpose: Shared constants for the external memory select and overlay block
// Assumes: 14-bit core addresses, 16-bit control registers
// Notes: Wait-state fields are widened by the wait-state mode bit
package emo_pkg;
  localparam int ADDR_W = 14;
  localparam int DATA_W = 16;
  // Control register addresses in data memory
  localparam logic [13:0] REG_SYSTEM_CONTROL = 14'h3fff;
  localparam logic [13:0] REG_WAIT_CONTROL = 14'h3ffe;
  localparam logic [13:0] REG_COMPOSITE_CONTROL = 14'h3ffd;
  localparam logic [13:0] REG_OVERLAY = 14'h3ffc;
  // Reset values
  localparam logic [15:0] SYSCTL_RESET = 16'h0000;
  localparam logic [15:0] WAITCTL_RESET = 16'h7fff;
  localparam logic [15:0] CMSCTL_RESET = 16'hfb00;
  localparam logic [15:0] OVERLAY_RESET = 16'h0000;
  // Writable bits; reserved bits stay zero
  localparam logic [15:0] SYSCTL_MASK = 16'h1c0f;
  localparam logic [15:0] WAITCTL_MASK = 16'hffff;
  localparam logic [15:0] CMSCTL_MASK = 16'hff00;
  localparam logic [15:0] OVERLAY_MASK = 16'h000f;
  // System control fields
  localparam int SYS_PM_WAIT_LSB = 0;
  localparam int SYS_BYTE_DISABLE = 3;
  localparam int SYS_SERIAL_ONE_CFG = 10;
  localparam int SYS_SERIAL_ONE_EN = 11;
  localparam int SYS_SERIAL_ZERO_EN = 12;
  // Wait control fields
  localparam int WAIT_IO_LSB = 0;
  localparam int WAIT_FIELD_W = 3;
  localparam int WAIT_DM_LSB = 12;
  localparam int WAIT_MODE_BIT = 15;
  // Composite control fields; enable order pm, dm, byte, io
  localparam int CMS_SEL_LSB = 8;
  localparam int CMS_PM = 0;
  localparam int CMS_DM = 1;
  localparam int CMS_BYTE = 2;
  localparam int CMS_IO = 3;
  localparam int CMS_BYTE_WAIT_LSB = 12;
  // Overlay register fields
  localparam int OVL_PM_LSB = 0;
  localparam int OVL_DM_LSB = 2;
  // Overlay select encodings
  localparam logic [1:0] OVL_RESERVED = 2'h0;
  localparam logic [1:0] OVL_ONE = 2'h1;
  localparam logic [1:0] OVL_TWO = 2'h2;
  localparam logic [13:0] OVERLAY_BASE = 14'h2000;
  // Access spaces
  localparam logic [1:0] SPACE_PM = 2'h0;
  localparam logic [1:0] SPACE_DM = 2'h1;
  localparam logic [1:0] SPACE_IO = 2'h2;
  localparam logic [1:0] SPACE_BYTE = 2'h3;
  localparam int IO_ADDR_W = 11;
  localparam int IO_REGION_LSB = 9;
  localparam logic [4:0] WAIT_MAX = 5'h0f;

  // Effective wait states from a field and the mode bit
  function automatic logic [4:0] wait_count(input logic [3:0] field, input logic mode);
    logic [4:0] doubled;
    doubled = {field, 1'b1};
    if (!mode)
      wait_count = {1'b0, field};
    else if (doubled > WAIT_MAX)
      wait_count = WAIT_MAX;
    else
      wait_count = doubled;
  endfunction : wait_count
endpackage : emo_pkg

// ---- emo_wait_counter.sv ----
// Purpose: Down counter that stretches an external access by its wait states
// Assumes: load has priority over counting
// Notes: count_zero decodes the held count, so it follows the register directly
`timescale 1ns/1ns
`default_nettype none
module emo_wait_counter #(
  parameter int WS_W = 5
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic load,
  input wire logic [WS_W-1:0] load_value,
  output logic count_zero
);
  logic [WS_W-1:0] count;

  // Load, then count down to zero
  always_ff @(posedge clk)
  begin
    if (reset)
      count <= '0;
    else if (load)
      count <= load_value;
    else if (count != '0)
      count <= count - 1'b1;
  end

  assign count_zero = (count == '0);
endmodule : emo_wait_counter
`default_nettype wire

// ---- emo_ext_partner.sv ----
// Purpose: Far-side model for the memory select block: mode driver and acknowledge wire
// Assumes: Mode driver enable is tied to chip reset
// Notes: Released mode pins show the inverse level so a late sample is caught
`timescale 1ns/1ns
`default_nettype none
module emo_ext_partner (
  input wire logic reset,
  input wire logic mode_host,
  input wire logic mode_style,
  input wire logic host_acknowledge,
  input wire logic host_acknowledge_oe,
  output logic flag_pin_two,
  output logic ack_style,
  output logic ack_pin
);
  // Mode driver gives the mode level while reset is held, then drives the inverse level
  assign flag_pin_two = reset ? mode_host : ~mode_host;
  assign ack_style = reset ? mode_style : ~mode_style;
  // Acknowledge wire with external pull-down
  assign ack_pin = host_acknowledge_oe ? host_acknowledge : 1'b0;
endmodule : emo_ext_partner
`default_nettype wire

// ---- ext_memory_select_overlay_test.sv ----
// Purpose: Self-checking bench for the memory select and overlay block
// Assumes: Inputs change on the falling edge, seed fixed
// Notes: Wait counts and addresses are worked out locally
`timescale 1ns/1ns
`default_nettype none
module ext_memory_select_overlay_test;
  logic clk = 0, reset = 1, busy = 0, bus_request = 0, req_valid = 0, req_fetch = 0;
  logic reg_write = 0, reg_read = 0, mode_host = 0, mode_style = 0;
  logic [1:0] req_space = 0;
  logic [13:0] req_addr = 0, reg_addr = 0, ext_addr;
  logic [7:0] req_page = 0, byte_page;
  logic [15:0] reg_wdata = 0, reg_rdata, rd;
  logic req_done, req_refused, bus_grant, pm_n, dm_n, io_n, bm_n, cms_n, ack, ack_oe, host_mode, sp0, sp1, sp1c;
  wire logic flag_pin_two, ack_style, ack_pin;
  int failures = 0, check_count = 0;

  emo_memory_select DUT (.clk(clk), .reset(reset), .flag_pin_two(flag_pin_two), .ack_style(ack_style),
    .host_ack_busy(busy), .bus_request(bus_request), .req_valid(req_valid), .req_space(req_space),
    .req_fetch(req_fetch), .req_addr(req_addr), .req_page(req_page), .reg_write(reg_write), .reg_read(reg_read),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .req_done(req_done),
    .req_refused(req_refused), .bus_grant(bus_grant), .ext_addr(ext_addr), .byte_page(byte_page),
    .program_space_select_n(pm_n), .data_space_select_n(dm_n), .io_space_select_n(io_n),
    .byte_space_select_n(bm_n), .composite_select_n(cms_n), .host_acknowledge(ack), .host_acknowledge_oe(ack_oe),
    .host_mode(host_mode), .serial_port_zero_en(sp0), .serial_port_one_en(sp1), .serial_port_one_cfg(sp1c));
  emo_ext_partner partner (.reset(reset), .mode_host(mode_host), .mode_style(mode_style), .host_acknowledge(ack),
    .host_acknowledge_oe(ack_oe), .flag_pin_two(flag_pin_two), .ack_style(ack_style), .ack_pin(ack_pin));

  // 125 MHz clock
  initial
  begin
    forever #4 clk = ~clk;
  end

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic report_and_stop;
    $display("Checks made %0d, mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : report_and_stop

  // Reset for 8 cycles with the mode levels on the shared pins
  task automatic do_reset(input logic h, input logic s);
    @(negedge clk);
    reset = 1;
    mode_host = h;
    mode_style = s;
    repeat (8) @(negedge clk);
    reset = 0;
  endtask : do_reset

  task automatic wr(input logic [13:0] a, input logic [15:0] d);
    @(negedge clk);
    reg_write = 1;
    reg_addr = a;
    reg_wdata = d;
    @(negedge clk);
    reg_write = 0;
  endtask : wr

  task automatic rdr(input logic [13:0] a);
    @(negedge clk);
    reg_read = 1;
    reg_addr = a;
    @(negedge clk);
    reg_read = 0;
    rd = reg_rdata;
  endtask : rdr

  // Effective wait states of a field under the mode bit
  function automatic int ws(input logic [3:0] f, input logic m);
    if (!m)
      return f;
    return (2 * f + 1 > 15) ? 15 : 2 * f + 1;
  endfunction : ws

  // One access; w is the wait count, -1 internal, -2 refused
  task automatic access(input logic [1:0] sp, input logic fe, input logic [13:0] ad, input logic [7:0] pg,
      input int w, input logic sel_on, input logic cms_on, input logic [13:0] ea);
    int n, lows, clows, stray;
    logic [3:0] sels;
    logic [13:0] seen;
    n = 0;
    lows = 0;
    clows = 0;
    stray = 0;
    seen = '0;
    @(negedge clk);
    req_valid = 1;
    req_space = sp;
    req_fetch = fe;
    req_addr = ad;
    req_page = pg;
    do
    begin
      @(posedge clk);
      #1;
      n++;
      sels = ~{bm_n, io_n, dm_n, pm_n};
      if (sels[sp] === 1'b1 || cms_n === 1'b0)
        seen = ext_addr;
      lows += (sels[sp] === 1'b1);
      clows += (cms_n === 1'b0);
      stray += ((sels & ~(4'h1 << sp)) != 4'h0);
    end
    while (req_done !== 1'b1 && req_refused !== 1'b1 && n < 40);
    @(negedge clk);
    req_valid = 0;
    check("answer cycle", n, (w < 0) ? 1 : w + 2);
    check("refusal", req_refused, w == -2);
    check("select length", lows, (w >= 0 && sel_on) ? w + 1 : 0);
    check("composite length", clows, (w >= 0 && cms_on) ? w + 1 : 0);
    check("other selects", stray, 0);
    if (w >= 0 && (sel_on || cms_on))
      check("address", seen, ea);
    if (sp == 2'h3) check("page", byte_page, pg);
  endtask : access

  // Watchdog of 50000 cycles, far above the fewer than one thousand cycles the tests need
  initial
  begin
    #400000;
    failures++;
    report_and_stop();
  end

  initial
  begin
    int r;
    logic [15:0] wc, cm, sc;
    logic [13:0] a;
    logic [1:0] dv, pv;
    void'($urandom(47));
    do_reset(0, 0);
    check("selects idle", {cms_n, bm_n, io_n, dm_n, pm_n}, 5'h1f);
    check("ack drive off", ack_oe, 0);
    check("full mode", host_mode, 0);
    rdr(14'h3fff);
    check("system reset", rd, emo_pkg::SYSCTL_RESET);
    rdr(14'h3ffe);
    check("wait reset", rd, emo_pkg::WAITCTL_RESET);
    rdr(14'h3ffd);
    check("composite enables", rd[11:8], 4'hb);
    rdr(14'h3ffc);
    check("overlay reset", rd, emo_pkg::OVERLAY_RESET);
    rdr(14'h3000);
    check("unmapped read", rd, 16'h0000);
    wr(14'h3fff, emo_pkg::SYSCTL_MASK);
    rdr(14'h3fff);
    check("system writable", rd, emo_pkg::SYSCTL_MASK);
    check("serial enables", {sp0, sp1, sp1c}, 3'h7);
    $display("test registers done");
    for (int i = 0; i < 8; i++)
    begin
      wc = 16'($urandom);
      cm = {8'($urandom), 8'h00};
      sc = 16'($urandom) & emo_pkg::SYSCTL_MASK;
      sc[3] = i[0];
      dv = 2'(i % 3);
      pv = 2'((i + 1) % 3);
      wr(14'h3ffe, wc);
      wr(14'h3ffd, cm);
      wr(14'h3fff, sc);
      wr(14'h3ffc, {12'h000, dv, pv});
      a = (i == 0) ? 14'h01ff : (i == 1) ? 14'h0600 : 14'($urandom) & 14'h07ff;
      r = a[10:9];
      access(2'h2, 0, a, 0, ws({1'b0, wc[3 * r +: 3]}, wc[15]), 1, cm[11], a);
      a = 14'h2000 | 14'($urandom);
      if (dv == 2'h0)
        access(2'h1, 0, a, 0, -1, 0, 0, 0);
      else
        access(2'h1, 0, a, 0, ws({1'b0, wc[14:12]}, wc[15]), 1, cm[9], {dv == 2'h2, a[12:0]});
      a = 14'h2000 | 14'($urandom);
      if (pv == 2'h0)
        access(2'h0, 1'($urandom), a, 0, -1, 0, 0, 0);
      else
        access(2'h0, 1'($urandom), a, 0, ws({1'b0, sc[2:0]}, wc[15]), 1, cm[8], {pv == 2'h2, a[12:0]});
      access(2'h1, 0, 14'($urandom) & 14'h1fff, 0, -1, 0, 0, 0);
      a = 14'($urandom);
      access(2'h3, 0, a, 8'($urandom), ws(cm[15:12], wc[15]), !sc[3], cm[10], a);
    end
    $display("test accesses done");
    @(negedge clk);
    bus_request = 1;
    req_valid = 1;
    req_space = 2'h2;
    repeat (3) @(negedge clk);
    check("bus grant", bus_grant, 1);
    check("selects released", {cms_n, io_n, req_done}, 3'h6);
    bus_request = 0;
    req_valid = 0;
    $display("test bus request done");
    for (int s = 0; s < 2; s++)
    begin
      do_reset(1, s[0]);
      check("host mode", host_mode, 1);
      for (int b = 0; b < 2; b++)
      begin
        @(negedge clk);
        busy = b[0];
        @(negedge clk);
        check("ack enable", ack_oe, s ? !b[0] : 1'b1);
        check("ack pin", ack_pin, !b[0]);
      end
      wr(14'h3ffc, 16'h0005);
      wr(14'h3ffe, 16'h9000);
      access(2'h0, 1, 14'h2001, 0, -2, 0, 0, 0);
      access(2'h0, 1, 14'h0001, 0, -1, 0, 0, 0);
      access(2'h1, 0, 14'h2003, 0, 3, 1, 1, 14'h0001);
    end
    $display("test host mode done");
    report_and_stop();
  end
endmodule : ext_memory_select_overlay_test
`default_nettype wire
